// [common/rfds_pkg.sv]
// Constants for the reference-frequency detection status register bank.
// Assumes a 32-bit AXI4-Lite master; printed offsets are word indices.
package rfds_pkg;

  // ==========================================================================
  // Address map (word indices; byte address is four times the index)
  localparam int unsigned ADDR_W          = 10;
  localparam logic [7:0]  IDX_REF_PAIR_A  = 8'h10;
  localparam logic [7:0]  IDX_REF_PAIR_B  = 8'h11;
  localparam logic [7:0]  IDX_REF_LAST    = 8'h12;
  localparam logic [7:0]  IDX_SYNC_STATUS = 8'h14;
  localparam logic [7:0]  IDX_LIMIT_A     = 8'h16;
  localparam logic [7:0]  IDX_LIMIT_B     = 8'h17;
  localparam logic [7:0]  IDX_EVENT_FLAGS = 8'h20;
  localparam logic [7:0]  IDX_EVENT_MASK  = 8'h21;

  // ==========================================================================
  // Reset values and writable fields
  localparam logic [7:0]  LIMIT_RESET     = 8'h33;
  localparam logic [7:0]  LIMIT_A_WMASK   = 8'h77;
  localparam logic [3:0]  FREQ_UNKNOWN    = 4'hF;
  localparam logic [2:0]  SYNC_UNKNOWN    = 3'h6;
  localparam logic [3:0]  RSVD_NIBBLE     = 4'h0;
  localparam logic [6:0]  EVENT_NONE      = 7'h00;

  // ==========================================================================
  // Monitor vector layout: five 4-bit reference codes, sync code, sync fail
  localparam int unsigned CODE_W          = 4;
  localparam int unsigned NUM_REFS        = 5;
  localparam int unsigned SYNC_LSB        = 20;
  localparam int unsigned FAIL_BIT        = 23;
  localparam int unsigned MON_W           = 24;
  localparam int unsigned EVT_SYNC_CODE   = 5;
  localparam int unsigned EVT_SYNC_FAIL   = 6;
  localparam int unsigned EVT_W           = 7;
  localparam int unsigned LIM_LO_LSB      = 0;
  localparam int unsigned LIM_HI_LSB      = 4;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : rfds_pkg

// [hdl/rfds_regs.sv]
// Frequency-detection status and range-limit control registers, AXI4-Lite slave.
// Assumes detection codes come from measurement logic on another clock,
// and that the master keeps valid and payload stable until taken.

// Notes on behaviour
// - Input e frequency is reported as a four-bit code, 1111 means undetected.
// - Input c code sits in bits 3:0 of the second detection register.
// - Input d code sits in bits 7:4 of the second detection register.
// - Frame input frequency is a three-bit code; unused codes mean undetected.
// - Bit 3 of the frame status register is one while frame input failed.
// - Input a range limit comes from bits 2:0 of the first limit register.
// - Input b range limit comes from bits 6:4 of the same register.
// - Both limit registers reset to 0x33, selecting code 011.
// - Inputs a and b codes sit in bits 3:0 and 7:4 of first register.
module rfds_regs (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // AXI4-Lite slave
  input  wire logic [rfds_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [rfds_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Measured codes from the monitoring circuitry
  input  wire logic [3:0]                 input_a_freq_code,
  input  wire logic [3:0]                 input_b_freq_code,
  input  wire logic [3:0]                 input_c_freq_code,
  input  wire logic [3:0]                 input_d_freq_code,
  input  wire logic [3:0]                 input_e_freq_code,
  input  wire logic [2:0]                 frame_input_freq_code,
  input  wire logic                       frame_input_failed,
  // Limit selections to the monitors, and the interrupt
  output logic [2:0]                      input_a_range_limit,
  output logic [2:0]                      input_b_range_limit,
  output logic [7:0]                      range_limit_b_value,
  output logic                            irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic                        aw_held;
    logic [7:0]                  aw_idx;
    logic                        w_held;
    logic [7:0]                  w_data;
    logic                        w_lane0;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [7:0]                  rdata;
    logic [1:0]                  rresp;
    logic [rfds_pkg::MON_W-1:0]  mon_s1;
    logic [rfds_pkg::MON_W-1:0]  mon_s2;
    logic [rfds_pkg::MON_W-1:0]  mon_s3;
    logic [rfds_pkg::MON_W-1:0]  mon_val;
    logic [rfds_pkg::EVT_W-1:0]  evt_flags;
    logic [rfds_pkg::EVT_W-1:0]  evt_mask;
    logic [7:0]                  limit_a;
    logic [7:0]                  limit_b;
    logic                        irq;
  } rfds_state_t;

  rfds_state_t st_reg;
  rfds_state_t st_next;

  localparam logic [rfds_pkg::MON_W-1:0] MON_RESET = {1'b0, rfds_pkg::SYNC_UNKNOWN,
    {rfds_pkg::NUM_REFS{rfds_pkg::FREQ_UNKNOWN}}};

  localparam rfds_state_t ST_RESET = '{
    aw_held: 1'b0, aw_idx: 8'h00, w_held: 1'b0, w_data: 8'h00, w_lane0: 1'b0,
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: rfds_pkg::RESP_OKAY,
    arready: 1'b1, rvalid: 1'b0, rdata: 8'h00, rresp: rfds_pkg::RESP_OKAY,
    mon_s1: MON_RESET, mon_s2: MON_RESET, mon_s3: MON_RESET, mon_val: MON_RESET,
    evt_flags: rfds_pkg::EVENT_NONE, evt_mask: rfds_pkg::EVENT_NONE,
    limit_a: rfds_pkg::LIMIT_RESET, limit_b: rfds_pkg::LIMIT_RESET, irq: 1'b0
  };

  // ==========================================================================
  // Helpers
  // Word index of a byte address
  function automatic logic [7:0] word_idx(input logic [rfds_pkg::ADDR_W-1:0] addr);
    word_idx = addr[rfds_pkg::ADDR_W-1:2];
  endfunction : word_idx

  // Four-bit code of reference n from the monitor vector
  function automatic logic [3:0] ref_code(input logic [rfds_pkg::MON_W-1:0] mon,
                                          input int unsigned n);
    ref_code = mon[n*rfds_pkg::CODE_W +: rfds_pkg::CODE_W];
  endfunction : ref_code

  // Read mux: bit 8 flags a mapped address
  function automatic logic [8:0] read_word(input logic [7:0] idx, input rfds_state_t s);
    read_word = {1'b1, 8'h00};
    case (idx)
      rfds_pkg::IDX_REF_PAIR_A:  read_word[7:0] = {ref_code(s.mon_val, 1),
                                                  ref_code(s.mon_val, 0)};
      rfds_pkg::IDX_REF_PAIR_B:  read_word[7:0] = {ref_code(s.mon_val, 3),
                                                  ref_code(s.mon_val, 2)};
      rfds_pkg::IDX_REF_LAST:    read_word[7:0] = {rfds_pkg::RSVD_NIBBLE,
                                                  ref_code(s.mon_val, 4)};
      rfds_pkg::IDX_SYNC_STATUS: read_word[7:0] = {rfds_pkg::RSVD_NIBBLE,
                                                  s.mon_val[rfds_pkg::FAIL_BIT],
                                                  s.mon_val[rfds_pkg::SYNC_LSB +: 3]};
      rfds_pkg::IDX_LIMIT_A:     read_word[7:0] = s.limit_a;
      rfds_pkg::IDX_LIMIT_B:     read_word[7:0] = s.limit_b;
      rfds_pkg::IDX_EVENT_FLAGS: read_word[7:0] = {1'b0, s.evt_flags};
      rfds_pkg::IDX_EVENT_MASK:  read_word[7:0] = {1'b0, s.evt_mask};
      default:                   read_word      = 9'h000;
    endcase
  endfunction : read_word

  // Addresses of registers that accept a write
  function automatic logic is_writable(input logic [7:0] idx);
    is_writable = (idx == rfds_pkg::IDX_LIMIT_A) || (idx == rfds_pkg::IDX_LIMIT_B) ||
                  (idx == rfds_pkg::IDX_EVENT_FLAGS) || (idx == rfds_pkg::IDX_EVENT_MASK);
  endfunction : is_writable

  // ==========================================================================
  // Next-state logic
  logic                       wr_do;
  logic [8:0]                 rd_word;
  logic [8:0]                 wr_word;
  logic [rfds_pkg::EVT_W-1:0] evt_set;
  logic [rfds_pkg::EVT_W-1:0] evt_clr;

  always_comb begin
    st_next = st_reg;
    evt_set = rfds_pkg::EVENT_NONE;
    evt_clr = rfds_pkg::EVENT_NONE;
    rd_word = 9'h000;
    wr_word = 9'h000;

    // Two-stage synchroniser, then accept only a value stable for two cycles
    st_next.mon_s1 = {frame_input_failed, frame_input_freq_code, input_e_freq_code,
                      input_d_freq_code, input_c_freq_code, input_b_freq_code,
                      input_a_freq_code};
    st_next.mon_s2 = st_reg.mon_s1;
    st_next.mon_s3 = st_reg.mon_s2;
    if (st_reg.mon_s2 == st_reg.mon_s3) begin
      st_next.mon_val = st_reg.mon_s3;
    end

    // Events: any code change, and a new failure of the frame input
    for (int i = 0; i < rfds_pkg::NUM_REFS; i++) begin
      evt_set[i] = ref_code(st_next.mon_val, i) != ref_code(st_reg.mon_val, i);
    end
    evt_set[rfds_pkg::EVT_SYNC_CODE] = st_next.mon_val[rfds_pkg::SYNC_LSB +: 3] !=
                                       st_reg.mon_val[rfds_pkg::SYNC_LSB +: 3];
    evt_set[rfds_pkg::EVT_SYNC_FAIL] = st_next.mon_val[rfds_pkg::FAIL_BIT] &&
                                       !st_reg.mon_val[rfds_pkg::FAIL_BIT];

    // Write address and data captured independently
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_idx  = word_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_held  = 1'b1;
      st_next.w_data  = s_axi_wdata[7:0];
      st_next.w_lane0 = s_axi_wstrb[0];
    end

    // Perform the write once both halves are held
    wr_do = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    if (wr_do) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      wr_word         = read_word(st_reg.aw_idx, st_reg);
      st_next.bresp   = wr_word[8] ? rfds_pkg::RESP_OKAY : rfds_pkg::RESP_SLVERR;
      if (st_reg.w_lane0 && is_writable(st_reg.aw_idx)) begin
        case (st_reg.aw_idx)
          rfds_pkg::IDX_LIMIT_A: st_next.limit_a = (st_reg.w_data & rfds_pkg::LIMIT_A_WMASK) |
                                   (rfds_pkg::LIMIT_RESET & ~rfds_pkg::LIMIT_A_WMASK);
          rfds_pkg::IDX_LIMIT_B:     st_next.limit_b  = st_reg.w_data;
          rfds_pkg::IDX_EVENT_FLAGS: evt_clr          = st_reg.w_data[rfds_pkg::EVT_W-1:0];
          rfds_pkg::IDX_EVENT_MASK:  st_next.evt_mask = st_reg.w_data[rfds_pkg::EVT_W-1:0];
          default:                   st_next.limit_b  = st_reg.limit_b;
        endcase
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_held && !st_next.bvalid;
    st_next.wready  = !st_next.w_held && !st_next.bvalid;

    // Sticky flags: a new event wins over a clear in the same cycle
    st_next.evt_flags = (st_reg.evt_flags & ~evt_clr) | evt_set;
    st_next.irq       = |(st_next.evt_flags & st_next.evt_mask);

    // Read channel: answer one cycle after the address is taken
    if (s_axi_arvalid && st_reg.arready) begin
      rd_word       = read_word(word_idx(s_axi_araddr), st_reg);
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_word[7:0];
      st_next.rresp  = rd_word[8] ? rfds_pkg::RESP_OKAY : rfds_pkg::RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  assign s_axi_awready       = st_reg.awready;
  assign s_axi_wready        = st_reg.wready;
  assign s_axi_bvalid        = st_reg.bvalid;
  assign s_axi_bresp         = st_reg.bresp;
  assign s_axi_arready       = st_reg.arready;
  assign s_axi_rvalid        = st_reg.rvalid;
  assign s_axi_rdata         = {24'h000000, st_reg.rdata};
  assign s_axi_rresp         = st_reg.rresp;
  assign input_a_range_limit = st_reg.limit_a[rfds_pkg::LIM_LO_LSB +: 3];
  assign input_b_range_limit = st_reg.limit_a[rfds_pkg::LIM_HI_LSB +: 3];
  assign range_limit_b_value = st_reg.limit_b;
  assign irq                 = st_reg.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic       ar_fire;
  logic [7:0] ar_idx;
  assign ar_fire = s_axi_arvalid && st_reg.arready;
  assign ar_idx  = word_idx(s_axi_araddr);

  property p_ref_last;
    ar_fire && ar_idx == rfds_pkg::IDX_REF_LAST |=>
      s_axi_rvalid && s_axi_rdata == {28'h0000000, $past(st_reg.mon_val[19:16])};
  endproperty
  a_ref_last: assert property (p_ref_last) else $error("input e code misread");

  property p_pair_b_lo;
    ar_fire && ar_idx == rfds_pkg::IDX_REF_PAIR_B |=>
      s_axi_rdata[3:0] == $past(st_reg.mon_val[11:8]);
  endproperty
  a_pair_b_lo: assert property (p_pair_b_lo) else $error("input c code misread");

  property p_pair_b_hi;
    ar_fire && ar_idx == rfds_pkg::IDX_REF_PAIR_B |=>
      s_axi_rdata[7:4] == $past(st_reg.mon_val[15:12]);
  endproperty
  a_pair_b_hi: assert property (p_pair_b_hi) else $error("input d code misread");

  property p_sync_code;
    $stable(frame_input_freq_code) [*5] |->
      st_reg.mon_val[22:20] == $past(frame_input_freq_code, 4);
  endproperty
  a_sync_code: assert property (p_sync_code) else $error("frame code not tracked");

  property p_sync_fail;
    ar_fire && ar_idx == rfds_pkg::IDX_SYNC_STATUS |=>
      s_axi_rdata[3] == $past(st_reg.mon_val[23]) && s_axi_rdata[7:4] == 4'h0;
  endproperty
  a_sync_fail: assert property (p_sync_fail) else $error("frame fail bit misread");

  property p_limit_a;
    wr_do && st_reg.aw_idx == rfds_pkg::IDX_LIMIT_A && st_reg.w_lane0 |=>
      input_a_range_limit == $past(st_reg.w_data[2:0]) && !st_reg.limit_a[3];
  endproperty
  a_limit_a: assert property (p_limit_a) else $error("input a limit not written");

  property p_limit_b;
    wr_do && st_reg.aw_idx == rfds_pkg::IDX_LIMIT_A && st_reg.w_lane0 |=>
      input_b_range_limit == $past(st_reg.w_data[6:4]) && !st_reg.limit_a[7];
  endproperty
  a_limit_b: assert property (p_limit_b) else $error("input b limit not written");

  property p_reset_val;
    $rose(rst_n) |-> st_reg.limit_a == 8'h33 && range_limit_b_value == 8'h33;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("limit reset value wrong");

  property p_pair_a;
    ar_fire && ar_idx == rfds_pkg::IDX_REF_PAIR_A |=>
      s_axi_rdata == {24'h000000, $past(st_reg.mon_val[7:0])};
  endproperty
  a_pair_a: assert property (p_pair_a) else $error("inputs a and b misread");

  property p_ro_write;
    wr_do && !is_writable(st_reg.aw_idx) |=>
      $stable(st_reg.limit_a) && $stable(st_reg.limit_b) && $stable(st_reg.evt_mask);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

  property p_irq;
    ##1 irq == |($past(st_next.evt_flags) & $past(st_next.evt_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  c_write_limit: cover property (wr_do && st_reg.aw_idx == rfds_pkg::IDX_LIMIT_A);
  c_read_sync:   cover property (ar_fire && ar_idx == rfds_pkg::IDX_SYNC_STATUS);
  c_irq_rise:    cover property ($rose(irq));
  c_set_clear:   cover property (|(evt_set & evt_clr));

endmodule : rfds_regs

// [bench/rfds_mon_model.sv]
// Behavioural model of the reference and frame monitors feeding the register bank.
// Assumes the bench calls set_codes to change what the monitors report.
module rfds_mon_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  output logic [3:0]      input_a_freq_code,
  output logic [3:0]      input_b_freq_code,
  output logic [3:0]      input_c_freq_code,
  output logic [3:0]      input_d_freq_code,
  output logic [3:0]      input_e_freq_code,
  output logic [2:0]      frame_input_freq_code,
  output logic            frame_input_failed
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Monitor outputs
  // Power up reporting nothing detected and no failure
  initial begin
    input_a_freq_code     = 4'hF;
    input_b_freq_code     = 4'hF;
    input_c_freq_code     = 4'hF;
    input_d_freq_code     = 4'hF;
    input_e_freq_code     = 4'hF;
    frame_input_freq_code = 3'h6;
    frame_input_failed    = 1'b0;
  end

  // New detection results land just after a clock edge, all at once
  task automatic set_codes(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c,
                           input logic [3:0] d, input logic [3:0] e, input logic [2:0] s,
                           input logic f);
    @(posedge core_clk);
    input_a_freq_code     <= a;
    input_b_freq_code     <= b;
    input_c_freq_code     <= c;
    input_d_freq_code     <= d;
    input_e_freq_code     <= e;
    frame_input_freq_code <= s;
    frame_input_failed    <= f;
  endtask : set_codes
endmodule : rfds_mon_model

// [bench/tb.sv]
// Self-checking bench for the frequency-detection register bank.
// Assumes an AXI4-Lite slave with registered readys and the monitor model beside it.
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals
  logic        core_clk;
  logic        rst_n;
  logic [9:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, ca, cb, cc, cd, ce;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  cs, lim_a, lim_b, jj;
  logic        cf;
  logic [7:0]  lim_b_val;
  logic [3:0]  kk;
  int          error_cnt, checks, cyc;

  // ==========================================================================
  // Clock, reset and instances
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  rfds_regs u_rfds_regs (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .input_a_freq_code(ca), .input_b_freq_code(cb), .input_c_freq_code(cc),
    .input_d_freq_code(cd), .input_e_freq_code(ce), .frame_input_freq_code(cs),
    .frame_input_failed(cf), .input_a_range_limit(lim_a), .input_b_range_limit(lim_b),
    .range_limit_b_value(lim_b_val), .irq(irq));

  rfds_mon_model u_rfds_mon_model (.core_clk(core_clk), .rst_n(rst_n),
    .input_a_freq_code(ca), .input_b_freq_code(cb), .input_c_freq_code(cc),
    .input_d_freq_code(cd), .input_e_freq_code(ce), .frame_input_freq_code(cs),
    .frame_input_failed(cf));

  // ==========================================================================
  // Reporting
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got 0x%08h expected 0x%08h", $time, got, exp);
    end
  endtask : chk

  // Cut a hung run short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==========================================================================
  // Bus tasks: readys are registered, so they are looked at mid-cycle
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, aw_rdy, w_rdy;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge core_clk);
      aw_rdy = awready;
      w_rdy = wready;
      @(posedge core_clk);
      if (!aw_ok && aw_rdy === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && w_rdy === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(negedge core_clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge core_clk);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge core_clk); while (arready !== 1'b1);
    @(posedge core_clk);
    arvalid <= 1'b0;
    do @(negedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge core_clk);
    rready <= 1'b0;
  endtask : axi_read

  // Read one register and compare its value and an OKAY response
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    axi_read(idx, rd, rsp);
    chk({30'h0, rsp}, {30'h0, rfds_pkg::RESP_OKAY});
    chk(rd, exp);
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irq_chk

  // ==========================================================================
  // Test sequence
  initial begin
    rst_n = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset contents and undetected codes
    rd_chk(rfds_pkg::IDX_LIMIT_A, 32'h33);
    rd_chk(rfds_pkg::IDX_LIMIT_B, 32'h33);
    chk({26'h0, lim_b, lim_a}, 32'h1B);
    rd_chk(rfds_pkg::IDX_REF_LAST, 32'h0F);
    rd_chk(rfds_pkg::IDX_SYNC_STATUS, 32'h06);
    // Every code value through every detection field
    for (int k = 0; k < 16; k++) begin
      kk = 4'(k);
      u_rfds_mon_model.set_codes(kk, kk + 4'h1, kk + 4'h2, kk + 4'h3, kk, kk[2:0], kk[0]);
      repeat (8) @(posedge core_clk);
      rd_chk(rfds_pkg::IDX_REF_PAIR_A, {24'h0, 4'(kk + 4'h1), kk});
      rd_chk(rfds_pkg::IDX_REF_PAIR_B, {24'h0, 4'(kk + 4'h3), 4'(kk + 4'h2)});
      rd_chk(rfds_pkg::IDX_REF_LAST, {28'h0, kk});
      rd_chk(rfds_pkg::IDX_SYNC_STATUS, {28'h0, kk[0], kk[2:0]});
    end
    // Writes to detection registers leave them alone
    axi_write(rfds_pkg::IDX_REF_PAIR_B, 32'hA5, rsp);
    chk({30'h0, rsp}, {30'h0, rfds_pkg::RESP_OKAY});
    rd_chk(rfds_pkg::IDX_REF_PAIR_B, 32'h21);
    // All eight limit codes on both fields, reserved bits read 0
    for (int j = 0; j < 8; j++) begin
      jj = 3'(j);
      axi_write(rfds_pkg::IDX_LIMIT_A, {24'h0, 1'b1, jj, 1'b1, ~jj}, rsp);
      rd_chk(rfds_pkg::IDX_LIMIT_A, {24'h0, 1'b0, jj, 1'b0, ~jj});
      chk({29'h0, lim_a}, {29'h0, ~jj});
      chk({29'h0, lim_b}, {29'h0, jj});
    end
    axi_write(rfds_pkg::IDX_LIMIT_B, 32'hA5, rsp);
    rd_chk(rfds_pkg::IDX_LIMIT_B, 32'hA5);
    chk({24'h0, lim_b_val}, 32'hA5);
    // Without the low byte lane a write leaves the register alone
    wstrb <= 4'hE;
    axi_write(rfds_pkg::IDX_LIMIT_B, 32'h5A, rsp);
    wstrb <= 4'hF;
    chk({30'h0, rsp}, {30'h0, rfds_pkg::RESP_OKAY});
    chk({24'h0, lim_b_val}, 32'hA5);
    // Unmapped address answers with an error
    axi_write(8'h30, 32'h1, rsp);
    chk({30'h0, rsp}, {30'h0, rfds_pkg::RESP_SLVERR});
    axi_read(8'h30, rd, rsp);
    chk({30'h0, rsp}, {30'h0, rfds_pkg::RESP_SLVERR});
    chk(rd, 32'h0);
    // Interrupt: clear, mask, raise on frame failure, clear again
    u_rfds_mon_model.set_codes(4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 3'h2, 1'b0);
    repeat (8) @(posedge core_clk);
    axi_write(rfds_pkg::IDX_EVENT_FLAGS, 32'h7F, rsp);
    rd_chk(rfds_pkg::IDX_EVENT_FLAGS, 32'h00);
    axi_write(rfds_pkg::IDX_EVENT_MASK, 32'h40, rsp);
    u_rfds_mon_model.set_codes(4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 3'h2, 1'b1);
    irq_chk(1'b0);
    repeat (6) @(posedge core_clk);
    irq_chk(1'b1);
    rd_chk(rfds_pkg::IDX_EVENT_FLAGS, 32'h40);
    axi_write(rfds_pkg::IDX_EVENT_MASK, 32'h00, rsp);
    irq_chk(1'b0);
    axi_write(rfds_pkg::IDX_EVENT_MASK, 32'h40, rsp);
    irq_chk(1'b1);
    axi_write(rfds_pkg::IDX_EVENT_FLAGS, 32'h40, rsp);
    irq_chk(1'b0);
    // Reset in mid-run restores the limit selections
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({24'h0, lim_b_val}, 32'h33);
    @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(rfds_pkg::IDX_LIMIT_A, 32'h33);
    close_out();
  end
endmodule : tb
